// ### rtl/sic_pkg.sv
// Purpose: Constants for the six-level interrupt controller
// Assumes: One 100 MHz clock, core-side register strobes
package sic_pkg;
    localparam int NUM_LEVELS = 6;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] PEND_RESET = 8'h00;
    localparam logic [7:0] PRIO_RESET = 8'h00;
    localparam int MASK_MASTER_BIT = 7;
    localparam int PRIO_C_BIT = 1;
    localparam int PRIO_B_BIT = 2;
    localparam int PRIO_A_BIT = 5;
    localparam int GRP_B0 = 0;
    localparam int GRP_B1 = 3;
    localparam int GRP_B2 = 4;
    localparam logic [7:0] VECTOR_STEP = 8'h02;
    localparam int SYNC_STAGES = 2;
    typedef enum logic [2:0] {
        GRP_UNUSED0 = 3'b000,
        GRP_CAB = 3'b001,
        GRP_ABC = 3'b010,
        GRP_ACB = 3'b011,
        GRP_BCA = 3'b100,
        GRP_CBA = 3'b101,
        GRP_BAC = 3'b110,
        GRP_UNUSED7 = 3'b111
    } sic_grp_t;
endpackage

// ### rtl/sic_ctrl.sv
// Purpose: Six-level interrupt controller
// Assumes: Pins already synchronous to clock_in; core drives strobes
// Notes: Pending write beats same-cycle sampling and acknowledge
`timescale 1ns/1ps
`default_nettype none
module sic_ctrl #(
    parameter bit LEVEL3_ON_BIT_TWO = 1'b0
) (
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic port_three_bit_zero_in,
    input wire logic port_three_bit_one_in,
    input wire logic port_three_bit_two_in,
    input wire logic port_three_bit_three_in,
    input wire logic comparator_in,
    input wire logic timer_zero_eoc_in,
    input wire logic timer_one_eoc_in,
    input wire logic serial_rx_in,
    input wire logic serial_tx_in,
    input wire logic serial_rx_enable_in,
    input wire logic sample_in,
    input wire logic ack_in,
    input wire logic global_enable_instruction_in,
    input wire logic global_disable_instruction_in,
    input wire logic return_from_service_instruction_in,
    input wire logic priority_order_wr_in,
    input wire logic request_enable_wr_in,
    input wire logic pending_wr_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] request_enable_register_out,
    output logic [7:0] pending_out,
    output logic irq_out,
    output logic [2:0] level_out,
    output logic [7:0] vector_out
);
    typedef struct packed {
        logic [3:0] pin_prev;
        logic [3:0] capture;
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [5:0] src_prev;
        logic [5:0] latch;
        logic [5:0] pend;
        logic [7:0] mask;
        logic [7:0] prio;
        logic irq;
        logic [2:0] level;
        logic [7:0] vector;
    } sic_state_t;

    sic_state_t st_r;
    sic_state_t st_nxt;
    logic [3:0] pin_now;
    logic [3:0] pin_edge;
    logic [5:0] src;
    logic [5:0] active;
    logic [2:0] win_lvl;
    logic win_any;

    ////////////////////////////////////////////////////////////////
    // Pin edge capture
    always_comb begin
        pin_now[0] = port_three_bit_two_in;
        pin_now[1] = port_three_bit_three_in;
        pin_now[2] = port_three_bit_one_in;
        pin_now[3] = LEVEL3_ON_BIT_TWO ? port_three_bit_two_in : port_three_bit_zero_in;
    end

    // Falling edges only; edge select bits are device dependent and left out
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_edge
            assign pin_edge[gi] = st_r.pin_prev[gi] & ~pin_now[gi];
        end
    endgenerate

    always_comb begin
        src[0] = st_r.sync2[0] | comparator_in;
        src[1] = st_r.sync2[1];
        src[2] = st_r.sync2[2] | comparator_in;
        src[3] = serial_rx_enable_in ? serial_rx_in : st_r.sync2[3];
        src[4] = timer_zero_eoc_in | serial_tx_in;
        src[5] = timer_one_eoc_in;
    end

    ////////////////////////////////////////////////////////////////
    // Arbitration
    function automatic logic [2:0] grp_pick(input logic [5:0] a, input logic first_hi,
                                             input logic [2:0] lo_l, input logic [2:0] hi_l);
        grp_pick = first_hi ? (a[hi_l] ? hi_l : lo_l) : (a[lo_l] ? lo_l : hi_l);
    endfunction

    logic [2:0] pick_a;
    logic [2:0] pick_b;
    logic [2:0] pick_c;
    logic has_a;
    logic has_b;
    logic has_c;
    logic [2:0] grp_sel;

    always_comb begin
        active = st_r.pend & st_r.mask[5:0] & {6{st_r.mask[sic_pkg::MASK_MASTER_BIT]}};
        has_a = active[3] | active[5];
        has_b = active[0] | active[2];
        has_c = active[1] | active[4];
        pick_a = grp_pick(active, st_r.prio[sic_pkg::PRIO_A_BIT], 3'd5, 3'd3);
        pick_b = grp_pick(active, st_r.prio[sic_pkg::PRIO_B_BIT], 3'd2, 3'd0);
        pick_c = grp_pick(active, st_r.prio[sic_pkg::PRIO_C_BIT], 3'd1, 3'd4);
        // Bits 6,7 never read
        grp_sel = {st_r.prio[sic_pkg::GRP_B2], st_r.prio[sic_pkg::GRP_B1], st_r.prio[sic_pkg::GRP_B0]};
        win_any = |active;
        win_lvl = 3'd0;
        case (sic_pkg::sic_grp_t'(grp_sel))
            sic_pkg::GRP_CAB: win_lvl = has_c ? pick_c : (has_a ? pick_a : pick_b);
            sic_pkg::GRP_ACB: win_lvl = has_a ? pick_a : (has_c ? pick_c : pick_b);
            sic_pkg::GRP_BCA: win_lvl = has_b ? pick_b : (has_c ? pick_c : pick_a);
            sic_pkg::GRP_CBA: win_lvl = has_c ? pick_c : (has_b ? pick_b : pick_a);
            sic_pkg::GRP_BAC: win_lvl = has_b ? pick_b : (has_a ? pick_a : pick_c);
            // Unused patterns fall back to A,B,C
            default: win_lvl = has_a ? pick_a : (has_b ? pick_b : pick_c);
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.pin_prev = pin_now;
        st_nxt.capture = pin_edge;
        st_nxt.sync1 = st_r.capture;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.src_prev = src;
        // Leading edge sets latch; held until sampled
        st_nxt.latch = (sample_in ? 6'h00 : st_r.latch) | (src & ~st_r.src_prev);
        if (sample_in) begin
            st_nxt.pend = st_r.pend | st_r.latch;
        end
        if (ack_in && win_any) begin
            st_nxt.pend[win_lvl] = 1'b0;
            st_nxt.mask[sic_pkg::MASK_MASTER_BIT] = 1'b0;
        end
        if (pending_wr_in) begin
            st_nxt.pend = wdata_in[5:0];
        end
        if (request_enable_wr_in) begin
            st_nxt.mask = wdata_in;
        end
        if (global_disable_instruction_in) begin
            st_nxt.mask[sic_pkg::MASK_MASTER_BIT] = 1'b0;
        end
        if (global_enable_instruction_in || return_from_service_instruction_in) begin
            st_nxt.mask[sic_pkg::MASK_MASTER_BIT] = 1'b1;
        end
        if (priority_order_wr_in) begin
            st_nxt.prio = wdata_in;
        end
        st_nxt.irq = win_any & ~(ack_in & win_any);
        st_nxt.level = win_lvl;
        st_nxt.vector = 8'(win_lvl) * sic_pkg::VECTOR_STEP;
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            st_r <= '0;
            st_r.mask <= sic_pkg::MASK_RESET;
            st_r.prio <= sic_pkg::PRIO_RESET;
            st_r.pin_prev <= 4'hf;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Priority-order register has no read path
    always_comb begin
        request_enable_register_out = st_r.mask;
        pending_out = {2'b00, st_r.pend};
        irq_out = st_r.irq;
        level_out = st_r.level;
        vector_out = st_r.vector;
    end

    ////////////////////////////////////////////////////////////////
    // Assertions
    a_sync_delay: assert property (@(posedge clock_in) disable iff (!nrst_in)
        st_r.capture[1] |-> ##2 st_r.sync2[1]) else $error("sync delay wrong");
    a_master_di: assert property (@(posedge clock_in) disable iff (!nrst_in)
        global_disable_instruction_in && !global_enable_instruction_in && !return_from_service_instruction_in
        && !request_enable_wr_in |=> !st_r.mask[7]) else $error("disable failed");
    a_master_return_from_service_instruction: assert property (@(posedge clock_in) disable iff (!nrst_in)
        return_from_service_instruction_in && !request_enable_wr_in |=> st_r.mask[7]) else $error("return failed");
    a_pend_write: assert property (@(posedge clock_in) disable iff (!nrst_in)
        pending_wr_in |=> pending_out == {2'b00, $past(wdata_in[5:0])}) else $error("pending write lost");
    a_no_irq_masked: assert property (@(posedge clock_in) disable iff (!nrst_in)
        !st_r.mask[7] |=> !irq_out) else $error("irq while disabled");
    a_vector_map: assert property (@(posedge clock_in) disable iff (!nrst_in)
        irq_out |-> vector_out == {4'h0, level_out, 1'b0}) else $error("bad vector");
    a_ack_clear: assert property (@(posedge clock_in) disable iff (!nrst_in)
        ack_in && win_any && !pending_wr_in |=> !st_r.pend[$past(win_lvl)]) else $error("winner kept");
    a_sample_move: assert property (@(posedge clock_in) disable iff (!nrst_in)
        sample_in && !pending_wr_in && !ack_in |=> (st_r.pend & $past(st_r.latch)) == $past(st_r.latch))
        else $error("sample lost");
    a_prio_reserved: assert property (@(posedge clock_in) disable iff (!nrst_in)
        $stable(st_r.prio[5:0]) && $stable(active) |-> $stable(win_lvl)) else $error("reserved bits matter");
    c_vectored: cover property (@(posedge clock_in) disable iff (!nrst_in) irq_out ##1 ack_in);
    c_level5: cover property (@(posedge clock_in) disable iff (!nrst_in) irq_out && level_out == 3'd5);
    c_polled: cover property (@(posedge clock_in) disable iff (!nrst_in) !st_r.mask[7] && pending_out != 8'h00);
    c_external: cover property (@(posedge clock_in) disable iff (!nrst_in) st_r.sync2[0] ##[1:4] sample_in);
    c_unused_order: cover property (@(posedge clock_in) disable iff (!nrst_in) irq_out && grp_sel == 3'b111);

    ////////////////////////////////////////////////////////////////
    // Arbitration checks
    a_grp_a_order: assert property (@(posedge clock_in) disable iff (!nrst_in)
        active[3] && active[5] |-> win_lvl != (st_r.prio[sic_pkg::PRIO_A_BIT] ? 3'd5 : 3'd3))
        else $error("group A order wrong");
    a_grp_b_order: assert property (@(posedge clock_in) disable iff (!nrst_in)
        active[0] && active[2] |-> win_lvl != (st_r.prio[sic_pkg::PRIO_B_BIT] ? 3'd2 : 3'd0))
        else $error("group B order wrong");
    a_grp_c_order: assert property (@(posedge clock_in) disable iff (!nrst_in)
        active[1] && active[4] |-> win_lvl != (st_r.prio[sic_pkg::PRIO_C_BIT] ? 3'd1 : 3'd4))
        else $error("group C order wrong");
    a_first_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
        (grp_sel == 3'b000 || grp_sel == 3'b010 || grp_sel == 3'b011 || grp_sel == 3'b111) && has_a
        |-> (win_lvl == 3'd3 || win_lvl == 3'd5))
        else $error("group A not first");
    a_first_b: assert property (@(posedge clock_in) disable iff (!nrst_in)
        (grp_sel == 3'b100 || grp_sel == 3'b110) && has_b |-> (win_lvl == 3'd0 || win_lvl == 3'd2))
        else $error("group B not first");
    a_first_c: assert property (@(posedge clock_in) disable iff (!nrst_in)
        (grp_sel == 3'b001 || grp_sel == 3'b101) && has_c |-> (win_lvl == 3'd1 || win_lvl == 3'd4))
        else $error("group C not first");
    a_grp_unused: assert property (@(posedge clock_in) disable iff (!nrst_in)
        (grp_sel == 3'b000 || grp_sel == 3'b111) && !has_a && has_b
        |-> (win_lvl == 3'd0 || win_lvl == 3'd2))
        else $error("unused order not fixed");
    a_level_range: assert property (@(posedge clock_in) disable iff (!nrst_in)
        irq_out |-> level_out < 3'd6)
        else $error("level out of range");
    a_vector_even: assert property (@(posedge clock_in) disable iff (!nrst_in)
        vector_out[0] == 1'b0)
        else $error("vector odd");
    a_vector_top: assert property (@(posedge clock_in) disable iff (!nrst_in)
        vector_out[7:4] == 4'h0)
        else $error("vector too high");
    a_no_win_idle: assert property (@(posedge clock_in) disable iff (!nrst_in)
        !win_any |=> !irq_out)
        else $error("irq without winner");
    a_irq_follows: assert property (@(posedge clock_in) disable iff (!nrst_in)
        win_any && !ack_in |=> irq_out)
        else $error("winner not flagged");
    a_irq_drop: assert property (@(posedge clock_in) disable iff (!nrst_in)
        ack_in && win_any |=> !irq_out)
        else $error("irq kept after ack");
    a_disable_blocks: assert property (@(posedge clock_in) disable iff (!nrst_in)
        !st_r.mask[sic_pkg::MASK_MASTER_BIT] |-> !win_any)
        else $error("winner while disabled");

    ////////////////////////////////////////////////////////////////
    // Register checks
    a_enable_set: assert property (@(posedge clock_in) disable iff (!nrst_in)
        global_enable_instruction_in |=> st_r.mask[7])
        else $error("enable failed");
    a_ack_master: assert property (@(posedge clock_in) disable iff (!nrst_in)
        ack_in && win_any && !global_enable_instruction_in && !return_from_service_instruction_in
        && !request_enable_wr_in |=> !st_r.mask[7])
        else $error("master kept on entry");
    a_mask_write: assert property (@(posedge clock_in) disable iff (!nrst_in)
        request_enable_wr_in && !ack_in && !global_disable_instruction_in && !global_enable_instruction_in
        && !return_from_service_instruction_in |=> st_r.mask == $past(wdata_in))
        else $error("mask write lost");
    a_prio_write: assert property (@(posedge clock_in) disable iff (!nrst_in)
        priority_order_wr_in |=> st_r.prio == $past(wdata_in))
        else $error("priority write lost");
    a_pend_top_zero: assert property (@(posedge clock_in) disable iff (!nrst_in)
        pending_out[7:6] == 2'b00)
        else $error("pending top bits set");

    ////////////////////////////////////////////////////////////////
    // Source checks
    a_rx_blocks_pin: assert property (@(posedge clock_in) disable iff (!nrst_in)
        serial_rx_enable_in && !serial_rx_in |-> !src[3])
        else $error("pin reached level 3");
    a_tx_source: assert property (@(posedge clock_in) disable iff (!nrst_in)
        timer_zero_eoc_in || serial_tx_in |-> src[4])
        else $error("level 4 source lost");
    a_timer_one_source: assert property (@(posedge clock_in) disable iff (!nrst_in)
        timer_one_eoc_in |-> src[5])
        else $error("level 5 source lost");
    a_comp_source: assert property (@(posedge clock_in) disable iff (!nrst_in)
        comparator_in |-> src[0] && src[2])
        else $error("comparator source lost");
    a_ext_zero: assert property (@(posedge clock_in) disable iff (!nrst_in)
        st_r.sync2[0] |-> src[0])
        else $error("level 0 pin lost");
    a_ext_one: assert property (@(posedge clock_in) disable iff (!nrst_in)
        st_r.sync2[1] |-> src[1])
        else $error("level 1 pin lost");
    a_ext_two: assert property (@(posedge clock_in) disable iff (!nrst_in)
        st_r.sync2[2] |-> src[2])
        else $error("level 2 pin lost");

    // Per-pin capture and sync chain
    generate
        for (gi = 0; gi < 4; gi++) begin : g_pin_chk
            a_edge_capture: assert property (@(posedge clock_in) disable iff (!nrst_in)
                pin_edge[gi] |=> st_r.capture[gi])
                else $error("pin edge not captured");
            a_pin_quiet: assert property (@(posedge clock_in) disable iff (!nrst_in)
                !pin_edge[gi] |=> !st_r.capture[gi])
                else $error("capture without edge");
            a_sync_first: assert property (@(posedge clock_in) disable iff (!nrst_in)
                st_r.capture[gi] |=> st_r.sync1[gi])
                else $error("first sync stage lost");
            a_sync_second: assert property (@(posedge clock_in) disable iff (!nrst_in)
                st_r.sync1[gi] |=> st_r.sync2[gi])
                else $error("second sync stage lost");
        end
    endgenerate

    // Per-level request path
    generate
        for (gi = 0; gi < 6; gi++) begin : g_lvl_chk
            a_latch_hold: assert property (@(posedge clock_in) disable iff (!nrst_in)
                st_r.latch[gi] && !sample_in |=> st_r.latch[gi])
                else $error("latch dropped early");
            a_latch_clear: assert property (@(posedge clock_in) disable iff (!nrst_in)
                sample_in && !(src[gi] && !st_r.src_prev[gi]) |=> !st_r.latch[gi])
                else $error("latch kept after sample");
            a_win_enabled: assert property (@(posedge clock_in) disable iff (!nrst_in)
                irq_out && level_out == 3'(gi) |-> $past(active[gi]))
                else $error("winner not enabled");
            a_vector_pair: assert property (@(posedge clock_in) disable iff (!nrst_in)
                irq_out && level_out == 3'(gi) |-> vector_out == 8'(2 * gi))
                else $error("vector pair wrong");
            a_pend_set: assert property (@(posedge clock_in) disable iff (!nrst_in)
                sample_in && st_r.latch[gi] && !pending_wr_in
                |=> st_r.pend[gi] || ($past(ack_in) && $past(win_any) && $past(win_lvl) == 3'(gi)))
                else $error("sampled request lost");
            a_pend_keep: assert property (@(posedge clock_in) disable iff (!nrst_in)
                st_r.pend[gi] && !pending_wr_in && !(ack_in && win_any && win_lvl == 3'(gi))
                |=> st_r.pend[gi])
                else $error("loser pending cleared");
            a_level_masked: assert property (@(posedge clock_in) disable iff (!nrst_in)
                !st_r.mask[gi] |=> !(irq_out && level_out == 3'(gi)))
                else $error("masked level won");
        end
    endgenerate
endmodule // sic_ctrl
`default_nettype wire

// ### bench/sic_core_model.sv
// Purpose: Core sequencer stand-in facing sic_ctrl
// Assumes: Opcode fetch every fourth cycle
// Notes: Ack fires once per request, so one level is cleared per interrupt cycle
`timescale 1ns/1ps
`default_nettype none
module sic_core_model (
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic irq_in,
    input wire logic ack_req_in,
    output logic sample_out,
    output logic ack_out
);
    logic [1:0] cnt_r;
    logic fired_r;
    ////////////////////////////////////////////////////////////////
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            cnt_r <= 2'h0;
            fired_r <= 1'b0;
            sample_out <= 1'b0;
            ack_out <= 1'b0;
        end else begin
            cnt_r <= cnt_r + 2'h1;
            sample_out <= (cnt_r == 2'h3);
            ack_out <= ack_req_in && irq_in && !fired_r;
            fired_r <= ack_req_in && (fired_r || irq_in);
        end
    end
endmodule // sic_core_model
`default_nettype wire

// ### bench/sic_ctrl_tb.sv
// Purpose: Self-checking bench for sic_ctrl
// Assumes: Core model samples every fourth cycle
// Notes: Table rows cover arbitration; hand tests cover sources and ack
`timescale 1ns/1ps
`default_nettype none
module sic_ctrl_tb;
    typedef struct {logic [7:0] pr; logic [7:0] mk; logic [7:0] pd; logic iq; logic [2:0] lv;} sic_row_t;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] p3 = 4'hf;
    logic [4:0] src = 5'h00;
    logic rxen = 1'b0;
    logic ackq = 1'b0;
    logic [5:0] strb = 6'h00;
    logic [7:0] wd = 8'h00;
    logic smp, ack, irq;
    logic [7:0] mk_o, pd_o, vec_o;
    logic [2:0] lv_o;
    int n_fail = 0;
    int total_checks = 0;
    int cyc = 0;
    logic [7:0] pexp [4] = '{8'h08, 8'h04, 8'h01, 8'h02};
    logic [7:0] sexp [5] = '{8'h05, 8'h10, 8'h20, 8'h10, 8'h08};
    sic_row_t rows [13] = '{'{8'h01, 8'hbf, 8'h3f, 1, 1}, '{8'h03, 8'hbf, 8'h3f, 1, 4},
        '{8'h08, 8'hbf, 8'h3f, 1, 5}, '{8'h28, 8'hbf, 8'h3f, 1, 3}, '{8'h09, 8'hbf, 8'h12, 1, 1},
        '{8'h10, 8'hbf, 8'h3f, 1, 2}, '{8'h14, 8'hbf, 8'h3f, 1, 0}, '{8'h11, 8'hbf, 8'h2d, 1, 2},
        '{8'h18, 8'hbf, 8'h32, 1, 5}, '{8'h00, 8'hbf, 8'h16, 1, 2}, '{8'hc8, 8'hbf, 8'h3f, 1, 5},
        '{8'h08, 8'h3f, 8'h3f, 0, 0}, '{8'h08, 8'h84, 8'h3f, 1, 2}};
    ////////////////////////////////////////////////////////////////
    sic_ctrl sic_ctrl_i (.clock_in(clk), .nrst_in(nrst), .port_three_bit_zero_in(p3[0]),
        .port_three_bit_one_in(p3[1]), .port_three_bit_two_in(p3[2]), .port_three_bit_three_in(p3[3]),
        .comparator_in(src[0]), .timer_zero_eoc_in(src[1]), .timer_one_eoc_in(src[2]),
        .serial_tx_in(src[3]), .serial_rx_in(src[4]), .serial_rx_enable_in(rxen), .sample_in(smp),
        .ack_in(ack), .global_enable_instruction_in(strb[3]), .global_disable_instruction_in(strb[4]),
        .return_from_service_instruction_in(strb[5]), .priority_order_wr_in(strb[0]),
        .request_enable_wr_in(strb[1]), .pending_wr_in(strb[2]), .wdata_in(wd),
        .request_enable_register_out(mk_o), .pending_out(pd_o), .irq_out(irq), .level_out(lv_o),
        .vector_out(vec_o));
    sic_core_model sic_core_model_i (.clock_in(clk), .nrst_in(nrst), .irq_in(irq), .ack_req_in(ackq),
        .sample_out(smp), .ack_out(ack));
    ////////////////////////////////////////////////////////////////
    task chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Strobe index: prio, mask, pend, enable, disable, return
    task wr(input int k, input logic [7:0] d);
        @(posedge clk);
        wd <= d;
        strb <= 6'h01 << k;
        @(posedge clk);
        strb <= 6'h00;
    endtask
    task settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task results;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    always #5 clk = ~clk;
    // Ceiling well above the roughly 300 cycles the tests need
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            $display("MISMATCH t=%0t timeout", $time);
            results;
        end
    end
    initial begin
        settle(6);
        chk(mk_o, 8'h00);
        chk(pd_o, 8'h00);
        chk({7'h0, irq}, 8'h00);
        @(posedge clk);
        nrst <= 1'b1;
        $display("test reset done");
        foreach (rows[i]) begin
            wr(0, rows[i].pr);
            wr(1, rows[i].mk);
            wr(2, rows[i].pd);
            settle(3);
            chk(pd_o, rows[i].pd);
            chk({7'h0, irq}, {7'h0, rows[i].iq});
            if (rows[i].iq) begin
                chk({5'h0, lv_o}, {5'h0, rows[i].lv});
                chk(vec_o, {4'h0, rows[i].lv, 1'b0});
            end
        end
        $display("test arbitration rows done");
        wr(1, 8'h00);
        for (int k = 0; k < 4; k++) begin
            wr(2, 8'h00);
            p3[k] <= 1'b0;
            settle(12);
            chk(pd_o, pexp[k]);
            @(posedge clk);
            p3[k] <= 1'b1;
        end
        wr(2, 8'h00);
        rxen <= 1'b1;
        p3[0] <= 1'b0;
        settle(12);
        chk(pd_o, 8'h00);
        @(posedge clk);
        p3[0] <= 1'b1;
        for (int k = 0; k < 5; k++) begin
            wr(2, 8'h00);
            src[k] <= 1'b1;
            @(posedge clk);
            src[k] <= 1'b0;
            settle(10);
            chk(pd_o, sexp[k]);
        end
        $display("test sources done");
        wr(0, 8'h08);
        wr(1, 8'hff);
        wr(2, 8'h24);
        settle(3);
        @(posedge clk);
        ackq <= 1'b1;
        settle(8);
        chk(pd_o, 8'h04);
        chk(mk_o, 8'h7f);
        chk({7'h0, irq}, 8'h00);
        @(posedge clk);
        ackq <= 1'b0;
        wr(5, 8'h00);
        settle(3);
        chk(mk_o, 8'hff);
        chk({5'h0, lv_o}, 8'h02);
        wr(4, 8'h00);
        settle(3);
        chk(mk_o, 8'h7f);
        chk({7'h0, irq}, 8'h00);
        wr(3, 8'h00);
        settle(3);
        chk(mk_o, 8'hff);
        $display("test service done");
        results;
    end
endmodule // sic_ctrl_tb
`default_nettype wire
